// *** shared/rx_dma_defs.svh ***
// Offsets, field positions, reset values and constants of the receive DMA control
`ifndef RX_DMA_DEFS_SVH
`define RX_DMA_DEFS_SVH

// Register byte offsets
`define RX_BASE_OFS 8'h0c
`define RX_POS_OFS 8'h10
`define DMA_STATUS_OFS 8'h14
`define DMA_CONTROL_OFS 8'h18
`define DMA_MASK_OFS 8'h1c

// Field positions
`define CTL_RUN_BIT 1
`define ST_RI_BIT 6
`define ST_RU_BIT 7
`define ST_RPS_BIT 8
`define ST_RS_LSB 17
`define ST_RS_MSB 19

// Reset values and constants
`define CONTROL_RESET 32'h0000_0000
`define BASE_RESET 32'h0000_0000
`define DESC_STRIDE 32'h0000_0010
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// *** shared/rx_dma_pkg.sv ***
// Types shared by the receive DMA control modules
package rx_dma_pkg;

    // Receive process states, Gray from stopped through fetch and wait to receive
    typedef enum logic [2:0] {
        rs_stopped = 3'h0,
        rs_fetch = 3'h1,
        rs_wait = 3'h3,
        rs_receive = 3'h2,
        rs_suspended = 3'h6
    } rx_state_t;

    // Decoded register selector
    typedef enum logic [2:0] {
        sel_none = 3'h0,
        sel_base = 3'h1,
        sel_pos = 3'h2,
        sel_status = 3'h3,
        sel_control = 3'h4,
        sel_mask = 3'h5
    } reg_sel_t;

endpackage

// *** shared/desc_fetch_if.sv ***
// Carrier between the receive controller and its descriptor fetcher
`timescale 1ns/1ns
interface desc_fetch_if;
    logic go;
    logic [31:0] addr;
    logic done;
    logic owned;

    // Controller side
    modport ctl
    (
        output go,
        output addr,
        input done,
        input owned
    );

    // Fetcher side
    modport fetch
    (
        input go,
        input addr,
        output done,
        output owned
    );
endinterface

// *** verilog/rx_desc_fetch.sv ***
// Descriptor ownership fetcher for the receive list
`timescale 1ns/1ns
module rx_desc_fetch
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    desc_fetch_if.fetch link,
    output logic desc_req,
    output logic [31:0] desc_addr,
    input wire logic desc_ack,
    input wire logic desc_owned
);
    logic next_req;
    logic [31:0] next_addr;
    logic next_done;
    logic next_owned;
    logic done;
    logic owned;

    assign link.done = done;
    assign link.owned = owned;

    // Request held until the memory side answers
    always_comb
    begin
        next_req = desc_req;
        next_addr = desc_addr;
        next_done = 1'b0;
        next_owned = owned;
        if (desc_req && desc_ack)
        begin
            next_req = 1'b0;
            next_done = 1'b1;
            next_owned = desc_owned;
        end
        else if (!desc_req && link.go)
        begin
            next_req = 1'b1;
            next_addr = link.addr;
        end
    end

    // Registers only
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            desc_req <= 1'b0;
            desc_addr <= 32'h0000_0000;
            done <= 1'b0;
            owned <= 1'b0;
        end
        else if (ce)
        begin
            desc_req <= next_req;
            desc_addr <= next_addr;
            done <= next_done;
            owned <= next_owned;
        end
    end
endmodule

// *** verilog/rx_dma_ctrl.sv ***
// Receive DMA start/stop control with AXI4-Lite registers
//
// The implementer's own choices: the AXI4-Lite register port and the register addresses.
`timescale 1ns/1ns
`include "rx_dma_defs.svh"

////////////////////////////////////////////////////////////////////////////////
// How it works
// [RQ1] Setting run bit starts running, fetches descriptor
// [RQ2] Fetch from base first, else saved position
// [RQ3] No owned descriptor: suspend, set unavailable flag
// [RQ4] Start acts only from the stopped state
// [RQ5] Software programs base before first start
// [RQ6] Clearing run bit stops after current frame
// [RQ7] Save next position, resume there on restart
// [RQ8] Stop acts only when running or suspended
// [RQ9] Software sets run bit before receiver enable
// [RQ10] Software clears receiver enable before run bit
// [RQ11] Receiver still enabled: no stop, no flag
// [RQ12] Run bit resets to zero, process stopped
module rx_dma_ctrl
    import rx_dma_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // AXI4-Lite slave
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // MAC receive side
    input wire logic mac_receiver_enable,
    input wire logic rx_frame_start,
    input wire logic rx_frame_end,
    // Descriptor memory side
    output logic desc_req,
    output logic [31:0] desc_addr,
    input wire logic desc_ack,
    input wire logic desc_owned,
    // Status
    output rx_state_t rx_process_state,
    output logic rx_process_stopped_flag,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    desc_fetch_if link ();

    logic aw_held, next_aw_held;
    logic [7:0] aw_addr, next_aw_addr;
    logic w_held, next_w_held;
    logic [31:0] w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic next_awready, next_wready, next_arready;
    logic next_bvalid, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;
    logic wr_go;

    logic [31:0] dma_engine_control, next_control;
    logic [31:0] rx_base, next_base;
    logic [31:0] rx_pos, next_pos;
    logic [2:0] dma_mask, next_mask;
    logic [2:0] sticky, next_sticky;
    logic started, next_started;
    logic fetch_go, next_fetch_go;
    rx_state_t next_state;
    logic next_stopped_flag;
    logic next_irq;
    logic rx_run_request;
    logic stop_ok;
    logic [31:0] dma_engine_status;
    logic [31:0] mask_word;
    logic [31:0] clr_word;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Address to register selector
    function automatic reg_sel_t decode(input logic [7:0] a);
        if (a == `RX_BASE_OFS)
            decode = sel_base;
        else if (a == `RX_POS_OFS)
            decode = sel_pos;
        else if (a == `DMA_STATUS_OFS)
            decode = sel_status;
        else if (a == `DMA_CONTROL_OFS)
            decode = sel_control;
        else if (a == `DMA_MASK_OFS)
            decode = sel_mask;
        else
            decode = sel_none;
    endfunction

    // Byte-lane merge of a write
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
        input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (s[i])
                r[i*8 +: 8] = d[i*8 +: 8];
        end
        merge = r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Descriptor fetcher

    assign link.go = fetch_go;
    assign link.addr = rx_pos;

    rx_desc_fetch u_fetch
    (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .link(link.fetch),
        .desc_req(desc_req),
        .desc_addr(desc_addr),
        .desc_ack(desc_ack),
        .desc_owned(desc_owned)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Register views

    // Status word assembled from sticky bits and state
    always_comb
    begin
        dma_engine_status = 32'h0000_0000;
        dma_engine_status[`ST_RPS_BIT:`ST_RI_BIT] = sticky;
        dma_engine_status[`ST_RS_MSB:`ST_RS_LSB] = rx_process_state;
    end

    assign rx_run_request = dma_engine_control[`CTL_RUN_BIT];
    assign stop_ok = !rx_run_request && !mac_receiver_enable; // RQ11
    assign wr_go = aw_held && w_held && !bvalid;

    // Write data merged into the mask view and into a clear pattern
    assign mask_word = merge({23'h000000, dma_mask, 6'h00}, w_data, w_strb);
    assign clr_word = merge(32'h0000_0000, w_data, w_strb);

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite channel handling

    // Address and data taken in either order, answer after both
    always_comb
    begin
        next_aw_held = aw_held;
        next_aw_addr = aw_addr;
        next_w_held = w_held;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_rvalid = rvalid;
        next_rdata = rdata;
        next_rresp = rresp;
        if (awvalid && awready)
        begin
            next_aw_held = 1'b1;
            next_aw_addr = awaddr;
        end
        if (wvalid && wready)
        begin
            next_w_held = 1'b1;
            next_w_data = wdata;
            next_w_strb = wstrb;
        end
        if (bvalid && bready)
            next_bvalid = 1'b0;
        if (wr_go)
        begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = (decode(aw_addr) == sel_none) ? `RESP_SLVERR : `RESP_OKAY;
        end
        if (rvalid && rready)
            next_rvalid = 1'b0;
        if (arvalid && arready)
        begin
            next_rvalid = 1'b1;
            next_rresp = `RESP_OKAY;
            if (decode(araddr) == sel_base)
                next_rdata = rx_base;
            else if (decode(araddr) == sel_pos)
                next_rdata = rx_pos;
            else if (decode(araddr) == sel_status)
                next_rdata = dma_engine_status;
            else if (decode(araddr) == sel_control)
                next_rdata = dma_engine_control;
            else if (decode(araddr) == sel_mask)
                next_rdata = {23'h000000, dma_mask, 6'h00};
            else
            begin
                next_rdata = 32'h0000_0000;
                next_rresp = `RESP_SLVERR;
            end
        end
        next_awready = !next_aw_held;
        next_wready = !next_w_held;
        next_arready = !next_rvalid;
    end

    // Bus registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            aw_addr <= 8'h00;
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            awready <= 1'b0;
            wready <= 1'b0;
            arready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= `RESP_OKAY;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= `RESP_OKAY;
        end
        else if (ce)
        begin
            aw_held <= next_aw_held;
            aw_addr <= next_aw_addr;
            w_held <= next_w_held;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            awready <= next_awready;
            wready <= next_wready;
            arready <= next_arready;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            rvalid <= next_rvalid;
            rdata <= next_rdata;
            rresp <= next_rresp;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receive process control

    // Register writes, then the state machine; hardware sets win over clears
    always_comb
    begin
        next_control = dma_engine_control;
        next_base = rx_base;
        next_pos = rx_pos;
        next_mask = dma_mask;
        next_sticky = sticky;
        next_started = started;
        next_fetch_go = 1'b0;
        next_state = rx_process_state;
        if (wr_go)
        begin
            if (decode(aw_addr) == sel_control)
            begin
                next_control = merge(dma_engine_control, w_data, w_strb);
                next_control = next_control & (32'h1 << `CTL_RUN_BIT);
            end
            else if (decode(aw_addr) == sel_base)
                next_base = merge(rx_base, w_data, w_strb);
            else if (decode(aw_addr) == sel_mask)
                next_mask = mask_word[`ST_RPS_BIT:`ST_RI_BIT];
            else if (decode(aw_addr) == sel_status)
                next_sticky = sticky & ~clr_word[`ST_RPS_BIT:`ST_RI_BIT];
        end
        case (rx_process_state)
            rs_stopped:
            begin
                if (rx_run_request) // RQ4
                begin
                    next_state = rs_fetch; // RQ1
                    next_fetch_go = 1'b1;
                    next_started = 1'b1;
                    if (!started)
                        next_pos = rx_base; // RQ2
                end
            end
            rs_fetch:
            begin
                if (link.done)
                begin
                    if (link.owned)
                        next_state = rs_wait;
                    else
                    begin
                        next_state = rs_suspended; // RQ3
                        next_sticky[`ST_RU_BIT - `ST_RI_BIT] = 1'b1; // RQ3
                    end
                end
            end
            rs_wait:
            begin
                if (rx_frame_start)
                    next_state = rs_receive;
                else if (stop_ok) // RQ8
                begin
                    next_state = rs_stopped;
                    next_sticky[`ST_RPS_BIT - `ST_RI_BIT] = 1'b1;
                end
            end
            rs_receive:
            begin
                if (rx_frame_end) // RQ6
                begin
                    next_pos = rx_pos + `DESC_STRIDE; // RQ7
                    next_sticky[0] = 1'b1;
                    if (stop_ok) // RQ6
                    begin
                        next_state = rs_stopped;
                        next_sticky[`ST_RPS_BIT - `ST_RI_BIT] = 1'b1;
                    end
                    else
                    begin
                        next_state = rs_fetch;
                        next_fetch_go = 1'b1;
                    end
                end
            end
            rs_suspended:
            begin
                if (stop_ok) // RQ8
                begin
                    next_state = rs_stopped;
                    next_sticky[`ST_RPS_BIT - `ST_RI_BIT] = 1'b1;
                end
                else if (rx_frame_start)
                begin
                    next_state = rs_fetch; // RQ2
                    next_fetch_go = 1'b1;
                end
            end
            default:
                next_state = rs_stopped;
        endcase
        next_stopped_flag = next_sticky[`ST_RPS_BIT - `ST_RI_BIT];
        next_irq = |(next_sticky & next_mask);
    end

    // Control registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            dma_engine_control <= `CONTROL_RESET; // RQ12
            rx_base <= `BASE_RESET;
            rx_pos <= `BASE_RESET;
            dma_mask <= 3'h0;
            sticky <= 3'h0;
            started <= 1'b0;
            fetch_go <= 1'b0;
            rx_process_state <= rs_stopped; // RQ12
            rx_process_stopped_flag <= 1'b0;
            irq <= 1'b0;
        end
        else if (ce)
        begin
            dma_engine_control <= next_control;
            rx_base <= next_base;
            rx_pos <= next_pos;
            dma_mask <= next_mask;
            sticky <= next_sticky;
            started <= next_started;
            fetch_go <= next_fetch_go;
            rx_process_state <= next_state;
            rx_process_stopped_flag <= next_stopped_flag;
            irq <= next_irq;
        end
    end

endmodule

// *** dv/rx_dma_ctrl_assertions.sv ***
// Port checks for the receive DMA control
`timescale 1ns/1ns
module rx_dma_ctrl_assertions
    import rx_dma_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic mac_receiver_enable,
    input wire logic rx_frame_start,
    input wire logic rx_frame_end,
    input wire logic desc_req,
    input wire logic [31:0] desc_addr,
    input wire logic desc_ack,
    input wire logic desc_owned,
    input wire rx_state_t rx_process_state,
    input wire logic rx_process_stopped_flag,
    input wire logic irq
);
    rx_state_t st;

    // Short alias of the state
    assign st = rx_process_state;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    ////////////////////////////////////////
    // Descriptor answers, request hold, stop, frame and reset checks
    sequence s_take(own);
        desc_req && desc_ack && desc_owned == own;
    endsequence
    property p_owned;
        s_take(1'b1) |-> ##2 st == rs_wait;
    endproperty
    a_owned: assert property (p_owned) else $error("owned not run");
    property p_unowned;
        s_take(1'b0) |-> ##2 st == rs_suspended;
    endproperty
    a_unowned: assert property (p_unowned) else $error("unowned not held");
    property p_req_hold;
        desc_req && !desc_ack |=> desc_req && $stable(desc_addr);
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("request dropped");
    property p_keep_run;
        st != rs_stopped && mac_receiver_enable |=> st != rs_stopped;
    endproperty
    a_keep_run: assert property (p_keep_run) else $error("stopped too soon");
    property p_frame;
        st == rs_receive && !rx_frame_end |=> st == rs_receive;
    endproperty
    a_frame: assert property (p_frame) else $error("frame cut short");
    property p_stop_flag;
        st != rs_stopped ##1 st == rs_stopped |-> ##[0:1] rx_process_stopped_flag;
    endproperty
    a_stop_flag: assert property (p_stop_flag) else $error("no stop flag");
    property p_wait_go;
        st == rs_wait && rx_frame_start && mac_receiver_enable |=> st == rs_receive;
    endproperty
    a_wait_go: assert property (p_wait_go) else $error("frame not taken");
    property p_reset;
        disable iff (1'b0) !aresetn |=> st == rs_stopped && !desc_req && !irq;
    endproperty
    a_reset: assert property (p_reset) else $error("reset state wrong");
endmodule

// *** dv/desc_mem_model.sv ***
// Host descriptor memory answering ownership
`timescale 1ns/1ns
module desc_mem_model
(
    input wire logic aclk,
    input wire logic desc_req,
    input wire logic owned,
    input wire logic slow,
    output logic desc_ack,
    output logic desc_owned
);
    int n = 0;

    // Answer after one or four cycles; owned line churns otherwise
    always @(posedge aclk)
    begin
        if (desc_req && !desc_ack && n >= (slow ? 4 : 1))
        begin
            desc_ack <= 1'b1;
            desc_owned <= owned;
            n <= 0;
        end
        else
        begin
            desc_ack <= 1'b0;
            desc_owned <= !desc_owned;
            n <= desc_req ? n + 1 : 0;
        end
    end
    initial desc_ack = 1'b0;
    initial desc_owned = 1'b0;
endmodule

// *** dv/tb_rx_dma_start_stop_control.sv ***
// Self-checking bench for the receive DMA start/stop control
`timescale 1ns/1ns
`include "rx_dma_defs.svh"
module tb_rx_dma_start_stop_control
    import rx_dma_pkg::*;
;
    logic aclk = '0, aresetn = '0, awvalid = '0, wvalid = '0, arvalid = '0;
    logic mac_receiver_enable = '0, rx_frame_start = '0, rx_frame_end = '0;
    logic owned = 1'b1, slow = '0, awready, wready, bvalid, arready, rvalid;
    logic ce = 1'b1;
    logic desc_req, desc_ack, desc_owned, rx_process_stopped_flag, irq;
    logic [7:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, desc_addr, rdata, rd, base, last_addr = '0;
    logic [31:0] seed = 32'h0001_4354;
    logic [1:0] bresp, rresp, resp;
    rx_state_t rx_process_state;
    int num_errors = 0, n_tests = 0;

    rx_dma_ctrl i_dut (.aclk, .aresetn, .ce, .awaddr, .awvalid, .awready, .wdata,
        .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid, .bready(1'b1), .araddr, .arvalid,
        .arready, .rdata, .rresp, .rvalid, .rready(1'b1), .mac_receiver_enable,
        .rx_frame_start, .rx_frame_end, .desc_req, .desc_addr, .desc_ack, .desc_owned,
        .rx_process_state, .rx_process_stopped_flag, .irq);
    desc_mem_model i_mem (.aclk, .desc_req, .owned, .slow, .desc_ack, .desc_owned);

    // Clock and descriptor address capture
    initial forever #5 aclk = ~aclk;
    always @(posedge aclk) if (desc_req && desc_ack) last_addr <= desc_addr;

    ////////////////////////////////////////
    // Helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [31:0] st_word(input logic [2:0] f, input rx_state_t s);
        return (32'(f) << `ST_RI_BIT) | (32'(s) << `ST_RS_LSB);
    endfunction
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end
        while (!bvalid);
        resp = bresp;
    endtask
    task automatic rd_reg(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end
        while (!rvalid);
        rd = rdata;
        resp = rresp;
    endtask
    task automatic wst(input rx_state_t e);
        int i;
        for (i = 0; i < 40 && rx_process_state !== e; i++) @(posedge aclk);
        chk("state", 32'(e), 32'(rx_process_state));
    endtask
    task automatic pulse(input bit e);
        rx_frame_end <= e;
        rx_frame_start <= !e;
        @(posedge aclk);
        rx_frame_end <= 1'b0;
        rx_frame_start <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic tend(input string s);
        $display("test %s done", s);
    endtask
    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Watchdog
    initial
    begin
        repeat (5000) @(posedge aclk);
        num_errors++;
        print_verdict();
    end

    ////////////////////////////////////////
    // Main sequence
    initial
    begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk("state", 32'(rs_stopped), 32'(rx_process_state));
        rd_reg(`DMA_CONTROL_OFS);
        chk("control", `CONTROL_RESET, rd);
        rd_reg(8'h40);
        chk("unmapped", 32'(`RESP_SLVERR), 32'(resp));
        wr(8'h40, 32'h0);
        chk("unmapped wr", 32'(`RESP_SLVERR), 32'(resp));
        tend("reset");
        seed = lfsr(seed);
        base = seed & 32'hffff_fff0;
        slow <= seed[3];
        wr(`RX_BASE_OFS, base);
        chk("wr resp", 32'(`RESP_OKAY), 32'(resp));
        wr(`DMA_CONTROL_OFS, 32'h2);
        mac_receiver_enable <= 1'b1;
        wst(rs_wait);
        chk("first desc", base, last_addr);
        pulse(0);
        pulse(1);
        wst(rs_wait);
        chk("next desc", base + `DESC_STRIDE, last_addr);
        rd_reg(`RX_POS_OFS);
        chk("position", base + `DESC_STRIDE, rd);
        tend("start");
        wr(`DMA_CONTROL_OFS, 32'h0);
        repeat (8) @(posedge aclk);
        chk("still run", 32'(rs_wait), 32'(rx_process_state));
        chk("no flag", 0, rx_process_stopped_flag);
        pulse(0);
        mac_receiver_enable <= 1'b0;
        repeat (6) @(posedge aclk);
        chk("in frame", 32'(rs_receive), 32'(rx_process_state));
        pulse(1);
        wst(rs_stopped);
        rd_reg(`DMA_STATUS_OFS);
        chk("status", st_word(3'h5, rs_stopped), rd);
        wr(`DMA_STATUS_OFS, 32'h1c0);
        rd_reg(`DMA_STATUS_OFS);
        chk("cleared", 32'h0, rd);
        tend("stop");
        owned <= 1'b0;
        wr(`RX_BASE_OFS, ~base & 32'hffff_fff0);
        wr(`DMA_CONTROL_OFS, 32'h2);
        mac_receiver_enable <= 1'b1;
        wst(rs_suspended);
        chk("resume desc", base + 2 * `DESC_STRIDE, last_addr);
        wr(`DMA_CONTROL_OFS, 32'h2);
        chk("restart", 32'(rs_suspended), 32'(rx_process_state));
        ce <= 1'b0;
        pulse(0);
        chk("frozen", 32'(rs_suspended), 32'(rx_process_state));
        ce <= 1'b1;
        wr(`DMA_MASK_OFS, 32'h80);
        repeat (2) @(posedge aclk);
        chk("irq on", 1, irq);
        rd_reg(`DMA_STATUS_OFS);
        chk("unavail", st_word(3'h2, rs_suspended), rd);
        wr(`DMA_STATUS_OFS, 32'h80);
        repeat (2) @(posedge aclk);
        chk("irq off", 0, irq);
        mac_receiver_enable <= 1'b0;
        wr(`DMA_CONTROL_OFS, 32'h0);
        wst(rs_stopped);
        tend("suspend");
        print_verdict();
    end
endmodule

bind rx_dma_ctrl rx_dma_ctrl_assertions i_chk (.aclk, .aresetn, .mac_receiver_enable,
    .rx_frame_start, .rx_frame_end, .desc_req, .desc_addr, .desc_ack, .desc_owned,
    .rx_process_state, .rx_process_stopped_flag, .irq);
